// file: dv/icd_au_model.sv
// icd_au_model.sv: timing phase source and arithmetic unit stand-in.
// assumes decoder chain pulses on the same clk.
`timescale 1ns/1ps
module icd_au_model (
   input  wire clk,
   input  wire rst_n,
   input  wire busy_q,
   input  wire chain_a_in_q,
   input  wire chain_m_in_q,
   input  wire slow,
   output wire timing_phase_zero,
   output wire timing_phase_five,
   output wire au_done
);
   logic [2:0] ph_q;
   logic [5:0] cnt_q;
   // eight phases; done is a level so a late wait still sees it
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_q <= 3'h0;
         cnt_q <= 6'h00;
      end else begin
         ph_q <= ph_q + 3'h1;
         if (chain_a_in_q || chain_m_in_q)
            cnt_q <= slow ? 6'h28 : 6'h02;
         else if (cnt_q != 6'h00)
            cnt_q <= cnt_q - 6'h01;
      end
   end
   assign timing_phase_zero = (ph_q == 3'h0);
   assign timing_phase_five = (ph_q == 3'h5);
   assign au_done = busy_q && (cnt_q == 6'h00);
endmodule // icd_au_model

// file: dv/icd_decoder_asserts.sv
// icd_decoder_asserts.sv: port checks of the order decoder.
// assumes one clock domain and the async active-low reset.
`timescale 1ns/1ps
`include "icd_defines.vh"
module icd_decoder_chk (
   input wire        clk,
   input wire        rst_n,
   input wire        decode_go,
   input wire [7:0]  second_instr_reg,
   input wire [7:0]  a_field,
   input wire [7:0]  m_low_digits,
   input wire        timing_phase_zero,
   input wire        timing_phase_five,
   input wire        busy_q,
   input wire        sel_a_q,
   input wire        sel_m_q,
   input wire [5:0]  ctl_group_q,
   input wire        chain_a_in_q,
   input wire [87:0] chain_start_line,
   input wire        counter_load_ok_q,
   input wire        low_digit_transfer_fn,
   input wire [7:0]  shift_control_reg,
   input wire        direct_selector_load_fn,
   input wire [7:0]  selector_reg
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // an order is taken only while idle
   wire go = decode_go && !busy_q;
   ////////////////////////////////////////
   property p_fn; low_digit_transfer_fn |-> $past(chain_start_line[42] && timing_phase_five); endproperty
   a_fn: assert property (p_fn) else $error("digit fn without cause");
   property p_shf; low_digit_transfer_fn |-> shift_control_reg == $past(m_low_digits); endproperty
   a_shf: assert property (p_shf) else $error("wrong shift factor");
   property p_dsl;
      direct_selector_load_fn |-> $past((chain_start_line[3] || chain_start_line[4]) && timing_phase_zero);
   endproperty
   a_dsl: assert property (p_dsl) else $error("selector load without cause");
   property p_sel; direct_selector_load_fn |-> selector_reg == $past(a_field); endproperty
   a_sel: assert property (p_sel) else $error("selector not A field");
   property p_nul;
      go && second_instr_reg inside {8'h00, 8'h90, 8'h91, 8'h95, 8'h96, 8'h97, 8'h99}
      |=> !busy_q && !sel_a_q && !sel_m_q;
   endproperty
   a_nul: assert property (p_nul) else $error("null order selected");
   property p_add; go && second_instr_reg == 8'h01 |=> busy_q && sel_a_q && sel_m_q; endproperty
   a_add: assert property (p_add) else $error("add selects missing");
   property p_ain; chain_a_in_q |-> $past(timing_phase_zero); endproperty
   a_ain: assert property (p_ain) else $error("input chain off phase zero");
   property p_idx; go && second_instr_reg inside {8'h85, 8'h86} |=> !counter_load_ok_q; endproperty
   a_idx: assert property (p_idx) else $error("counter load on 85 or 86");
endmodule // icd_decoder_chk
bind icd_decoder icd_decoder_chk i_chk (.clk, .rst_n, .decode_go, .second_instr_reg, .a_field,
   .m_low_digits, .timing_phase_zero, .timing_phase_five, .busy_q, .sel_a_q, .sel_m_q,
   .ctl_group_q, .chain_a_in_q, .chain_start_line, .counter_load_ok_q, .low_digit_transfer_fn,
   .shift_control_reg, .direct_selector_load_fn, .selector_reg);

// file: dv/tb_top.sv
// tb_top.sv: corner and random orders, chain uses counted per order.
// assumes the decoder, its bound checker and the unit stand-in.
`timescale 1ns/1ps
`include "icd_defines.vh"
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, decode_go = 1'b0, slow = 1'b0;
   logic m_is_fast_reg = 1'b0, au_double = 1'b0, au_multiply = 1'b0, transfer_taken = 1'b0;
   logic [7:0] second_instr_reg = 8'h00, a_field = 8'h00, m_low_digits = 8'h00;
   wire au_done, timing_phase_zero, timing_phase_five, busy_q, mem_addr_fixed_q;
   wire chain_a_in_q, chain_m_in_q, chain_result_q, low_digit_transfer_fn, direct_selector_load_fn;
   wire [7:0] shift_control_reg, selector_reg;
   wire [14:0] mem_addr_q;
   wire instruction_code_line;
   logic [31:0] seed = 32'h0000001D;
   int fails = 0, n_compared = 0;
   logic [7:0] codes [25] = '{8'h01, 8'h02, 8'h14, 8'h34, 8'h44, 8'h60, 8'h65, 8'h43, 8'h40,
      8'h50, 8'h55, 8'h72, 8'h70, 8'h80, 8'h85, 8'h29, 8'h09, 8'h00, 8'h90, 8'h91, 8'h95,
      8'h96, 8'h97, 8'h99, 8'h3A};
   icd_decoder i_dut (.clk, .rst_n, .decode_go, .second_instr_reg, .a_field, .m_low_digits,
      .m_is_fast_reg, .au_double, .au_multiply, .au_done, .transfer_taken,
      .timing_phase_zero, .timing_phase_five, .instruction_code_line, .ctl_group_q(),
      .au_group_q(), .pc_stage_line(), .chain_start_line(), .sel_a_q(), .sel_m_q(),
      .chain_a_in_q, .chain_m_in_q, .chain_result_q, .mem_ref_q(), .mem_addr_fixed_q,
      .mem_addr_q, .counter_load_ok_q(), .busy_q, .low_digit_transfer_fn,
      .shift_control_reg, .direct_selector_load_fn, .selector_reg);
   icd_au_model i_au (.clk, .rst_n, .busy_q, .chain_a_in_q, .chain_m_in_q, .slow,
      .timing_phase_zero, .timing_phase_five, .au_done);
   ////////////////////////////////////////
   // 25 MHz clock
   initial begin
      forever #20 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // expected {a-in uses, m-in uses, result uses, direct selector load}
   function automatic logic [7:0] exp_f(input logic [7:0] c, input logic db, mu, mf);
      case (c)
         8'h01, 8'h02, 8'h14, 8'h34, 8'h44: return {db ? (mu ? 3'h4 : 3'h2) : 3'h1,
            1'b0, mf, db ? 2'h2 : 2'h1, 1'b0};
         8'h60: return {3'h1, 1'b0, mf, 2'h1, 1'b0};
         8'h65: return {3'h1, 2'h1, 2'h1, 1'b0};
         8'h43: return {3'h0, 1'b0, mf, 2'h1, 1'b0};
         8'h40: return {3'h0, 2'h1, 1'b0, mf, 1'b1};
         8'h55: return {3'h1, 2'h1, 2'h1, 1'b1};
         8'h50: return {3'h0, 2'h1, 2'h1, 1'b1};
         8'h72, 8'h70, 8'h29: return {3'h0, 2'h1, 2'h0, 1'b1};
         8'h80, 8'h85: return {3'h1, 2'h0, 2'h0, 1'b0};
         default: return 8'h00;
      endcase
   endfunction
   task automatic chk(input logic ok, input string s);
      n_compared++;
      if (!ok) begin
         fails++;
         $display("mismatch at %0t: %s", $time, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // one order: decode, count chain pulses until idle, compare
   task automatic run(input logic [7:0] c);
      logic [7:0] e, g;
      logic fx, fn, ar, nv;
      int n;
      ar = c inside {8'h01, 8'h02, 8'h14, 8'h34, 8'h44};
      nv = c inside {8'h00, 8'h90, 8'h91, 8'h95, 8'h96, 8'h97, 8'h99, 8'h3A};
      @(posedge clk);
      #1;
      second_instr_reg = c;
      a_field = 8'(rnd());
      m_low_digits = 8'(rnd());
      m_is_fast_reg = (ar || c inside {8'h60, 8'h43, 8'h40}) && 1'(rnd());
      au_double = ar && 1'(rnd());
      au_multiply = ar && 1'(rnd());
      // taken transfers only end conditional orders early, the chain uses stay
      transfer_taken = c inside {8'h70, 8'h72, 8'h80, 8'h85} && 1'(rnd());
      slow = 1'(rnd());
      decode_go = 1'b1;
      @(posedge clk);
      #1;
      decode_go = 1'b0;
      g = 8'h00;
      fx = 1'b0;
      fn = 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
         if (n == 1) chk(instruction_code_line === !nv, "code line");
         g[7:5] = g[7:5] + 3'(chain_a_in_q);
         g[4:3] = g[4:3] + 2'(chain_m_in_q);
         g[2:1] = g[2:1] + 2'(chain_result_q);
         g[0] = g[0] | direct_selector_load_fn;
         fx = fx | (mem_addr_fixed_q === 1'b1 && mem_addr_q === `ICD_DISP_LOC);
         fn = fn | (low_digit_transfer_fn === 1'b1);
         if (low_digit_transfer_fn) chk(shift_control_reg === m_low_digits, "shift factor");
      end while ((busy_q !== 1'b0 || n < 3) && n < 400);
      if (n >= 400) chk(1'b0, "order never ended");
      if (n >= 400) tally_and_finish();
      e = exp_f(c, au_double, au_multiply, m_is_fast_reg);
      chk((g ^ e) === 8'h00, "chain uses");
      if (e[0]) chk(selector_reg === a_field, "selector not A field");
      if (c == 8'h50 || c == 8'h55) chk(fn, "no shift factor transfer");
      if (c == 8'h09 || c == 8'h29) chk(fx, "display location");
   endtask
   // reset, every code once, then random picks
   initial begin
      repeat (4) @(posedge clk);
      #1;
      rst_n = 1'b1;
      foreach (codes[i]) run(codes[i]);
      repeat (40) run(codes[rnd() % 25]);
      tally_and_finish();
   end
endmodule // tb_top

// file: hw/icd_decoder.v
// icd_decoder.v: classifies the order in the second instruction register
// into control groups, pc stages, chain-start lines and operand selects,
// and sequences the fast-register chain uses of the order.
// assumes the order code, fields and timing phases are driven on clk.
`timescale 1ns/1ps
`include "icd_defines.vh"

module icd_decoder (
   clk,
   rst_n,
   decode_go,
   second_instr_reg,
   a_field,
   m_low_digits,
   m_is_fast_reg,
   au_double,
   au_multiply,
   au_done,
   transfer_taken,
   timing_phase_zero,
   timing_phase_five,
   instruction_code_line,
   ctl_group_q,
   au_group_q,
   pc_stage_line,
   chain_start_line,
   sel_a_q,
   sel_m_q,
   chain_a_in_q,
   chain_m_in_q,
   chain_result_q,
   mem_ref_q,
   mem_addr_fixed_q,
   mem_addr_q,
   counter_load_ok_q,
   busy_q,
   low_digit_transfer_fn,
   shift_control_reg,
   direct_selector_load_fn,
   selector_reg
);
   input  wire                     clk;
   input  wire                     rst_n;
   input  wire                     decode_go;
   input  wire [`ICD_CODE_W-1:0]   second_instr_reg;
   input  wire [`ICD_SEL_W-1:0]    a_field;
   input  wire [7:0]               m_low_digits;
   input  wire                     m_is_fast_reg;
   input  wire                     au_double;
   input  wire                     au_multiply;
   input  wire                     au_done;
   input  wire                     transfer_taken;
   input  wire                     timing_phase_zero;
   input  wire                     timing_phase_five;
   output reg                      instruction_code_line;
   output reg  [`ICD_GRP_W-1:0]    ctl_group_q;
   output reg  [`ICD_GRP_W-1:0]    au_group_q;
   output reg  [`ICD_STG_W-1:0]    pc_stage_line;
   output reg  [`ICD_CHN_W-1:0]    chain_start_line;
   output reg                      sel_a_q;
   output reg                      sel_m_q;
   output reg                      chain_a_in_q;
   output reg                      chain_m_in_q;
   output reg                      chain_result_q;
   output reg                      mem_ref_q;
   output reg                      mem_addr_fixed_q;
   output reg  [`ICD_ADDR_W-1:0]   mem_addr_q;
   output reg                      counter_load_ok_q;
   output reg                      busy_q;
   output wire                     low_digit_transfer_fn;
   output wire [7:0]               shift_control_reg;
   output wire                     direct_selector_load_fn;
   output wire [`ICD_SEL_W-1:0]    selector_reg;

   // sequencer states, one-hot
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_AIN  = 4'b0010;
   localparam [3:0] ST_WAIT = 4'b0100;
   localparam [3:0] ST_RES  = 4'b1000;

   reg  [5:0]            cls_d;
   reg                   valid_d;
   reg                   use_a_d;
   reg                   use_m_d;
   reg                   use_ain_d;
   reg                   use_min_d;
   reg                   use_res_d;
   reg                   m_direct_d;
   reg                   low_dig_d;
   reg                   sel_ld_b_d;
   reg                   disp_d;
   reg                   cond_d;
   reg                   ctr_ok_d;
   reg  [2:0]            ain_n_d;
   reg  [1:0]            res_n_d;
   reg  [6:0]            num;

   reg  [3:0]            st_q;
   reg  [2:0]            ain_left_q;
   reg  [1:0]            res_left_q;
   reg                   cond_q;
   reg  [2:0]            stage_q;
   reg  [`ICD_STG_W-1:0] stg_base_q;
   reg                   m_first_q;
   reg                   m_dir_q;

   ////////////////////////////////////////////////////////////////////////
   // order number from the two bcd digits of the code
   always @* begin
      num = ({3'h0, second_instr_reg[7:4]} * 7'h0A) + {3'h0, second_instr_reg[3:0]};
      // a digit above nine is no order, so it lands past every class
      if (second_instr_reg[7:4] > 4'h9 || second_instr_reg[3:0] > 4'h9) begin
         num = 7'h7F;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // class decode; specific classes except display write 39 win over the wide arithmetic range,
   // so 40-48 and 50-59 fall to store, fetch and shift where listed
   always @* begin
      cls_d      = `ICD_CL_NONE;
      use_a_d    = 1'b0;
      use_m_d    = 1'b0;
      use_ain_d  = 1'b0;
      use_min_d  = 1'b0;
      use_res_d  = 1'b0;
      m_direct_d = 1'b0;
      low_dig_d  = 1'b0;
      sel_ld_b_d = 1'b0;
      disp_d     = 1'b0;
      cond_d     = 1'b0;
      ctr_ok_d   = 1'b0;
      if (num == 7'd43 || num == 7'd48) begin
         cls_d = `ICD_CL_FETCH;
      end else if ((num >= 7'd40 && num <= 7'd42) ||
                   (num >= 7'd45 && num <= 7'd47)) begin
         cls_d = `ICD_CL_STORE;
      end else if (num >= 7'd50 && num <= 7'd53) begin
         cls_d = `ICD_CL_SHIFT_S;
      end else if (num >= 7'd55 && num <= 7'd59) begin
         cls_d = `ICD_CL_SHIFT_D;
      end else if ((num >= 7'd1 && num <= 7'd6) || num == 7'd11 ||
                   num == 7'd12 || (num >= 7'd14 && num <= 7'd16) ||
                   (num >= 7'd20 && num <= 7'd27) ||
                   (num >= 7'd30 && num <= 7'd32) ||
                   (num >= 7'd34 && num <= 7'd57)) begin
         cls_d = `ICD_CL_ARITH;
      end else if (num >= 7'd60 && num <= 7'd64) begin
         cls_d = `ICD_CL_EXT_L;
      end else if (num == 7'd65 || num == 7'd66) begin
         cls_d = `ICD_CL_EXT_X;
      end else if (num == 7'd70 || num == 7'd71 ||
                   num == 7'd75 || num == 7'd76) begin
         cls_d = `ICD_CL_CMP_AM;
      end else if (num >= 7'd72 && num <= 7'd74) begin
         cls_d = `ICD_CL_CMP_A;
      end else if (num >= 7'd80 && num <= 7'd83) begin
         cls_d = `ICD_CL_INDEX;
      end else if (num == 7'd85 || num == 7'd86) begin
         cls_d = `ICD_CL_INDEX_NC;
      end else if (num == 7'd9 || num == 7'd19) begin
         cls_d = `ICD_CL_DISP_R;
      end else if (num == 7'd29 || num == 7'd39) begin
         cls_d = `ICD_CL_DISP_W;
      end
      // per-class operand and chain use
      case (cls_d)
         `ICD_CL_ARITH, `ICD_CL_EXT_L: begin
            use_a_d   = 1'b1;
            use_m_d   = 1'b1;
            use_ain_d = 1'b1;
            use_res_d = 1'b1;
            use_min_d = m_is_fast_reg;
         end
         `ICD_CL_EXT_X: begin
            use_a_d   = 1'b1;
            use_m_d   = 1'b1;
            use_ain_d = 1'b1;
            use_res_d = 1'b1;
            use_min_d = 1'b1;
         end
         `ICD_CL_SHIFT_S: begin
            use_a_d    = 1'b1;
            use_min_d  = 1'b1;
            use_res_d  = 1'b1;
            m_direct_d = 1'b1;
            low_dig_d  = 1'b1;
         end
         `ICD_CL_SHIFT_D: begin
            use_a_d    = 1'b1;
            use_min_d  = 1'b1;
            use_ain_d  = 1'b1;
            use_res_d  = 1'b1;
            m_direct_d = 1'b1;
            low_dig_d  = 1'b1;
         end
         `ICD_CL_FETCH: begin
            use_m_d   = 1'b1;
            use_res_d = 1'b1;
            use_min_d = m_is_fast_reg;
         end
         `ICD_CL_STORE: begin
            use_a_d    = 1'b1;
            use_min_d  = 1'b1;
            use_res_d  = m_is_fast_reg;
            m_direct_d = 1'b1;
         end
         `ICD_CL_CMP_AM: begin
            use_a_d    = 1'b1;
            use_m_d    = 1'b1;
            use_min_d  = 1'b1;
            m_direct_d = 1'b1;
            sel_ld_b_d = 1'b1;
            cond_d     = 1'b1;
         end
         `ICD_CL_CMP_A: begin
            use_a_d    = 1'b1;
            use_min_d  = 1'b1;
            m_direct_d = 1'b1;
            sel_ld_b_d = 1'b1;
            cond_d     = 1'b1;
         end
         `ICD_CL_INDEX, `ICD_CL_INDEX_NC: begin
            use_m_d   = 1'b1;
            use_ain_d = 1'b1;
            cond_d    = 1'b1;
            ctr_ok_d  = (cls_d == `ICD_CL_INDEX);
         end
         `ICD_CL_DISP_R: begin
            use_m_d = 1'b1;
            disp_d  = 1'b1;
         end
         `ICD_CL_DISP_W: begin
            use_a_d    = 1'b1;
            use_m_d    = 1'b1;
            use_min_d  = 1'b1;
            m_direct_d = 1'b1;
            disp_d     = 1'b1;
         end
         default: begin
            use_a_d = 1'b0;
         end
      endcase
      valid_d = (cls_d != `ICD_CL_NONE);
   end

   ////////////////////////////////////////////////////////////////////////
   // chain use counts: double arithmetic orders double the A-input and result uses, double multiply
   // takes four A-input uses
   always @* begin
      ain_n_d = 3'd0;
      res_n_d = 2'd0;
      if (use_ain_d) begin
         ain_n_d = 3'd1;
         if (cls_d == `ICD_CL_ARITH && au_double) begin
            ain_n_d = au_multiply ? 3'd4 : 3'd2;
         end
      end
      if (use_res_d) begin
         res_n_d = 2'd1;
         if (cls_d == `ICD_CL_ARITH && au_double) begin
            res_n_d = 2'd2;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // group encoders: control and arithmetic, latched per order
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         instruction_code_line <= 1'b0;
         ctl_group_q           <= `ICD_CL_NONE;
         au_group_q            <= `ICD_CL_NONE;
         sel_a_q               <= 1'b0;
         sel_m_q               <= 1'b0;
         mem_addr_fixed_q      <= 1'b0;
         mem_addr_q            <= {`ICD_ADDR_W{1'b0}};
         counter_load_ok_q     <= 1'b0;
         cond_q                <= 1'b0;
         m_dir_q               <= 1'b0;
         stg_base_q            <= {`ICD_STG_W{1'b0}};
      end else if (decode_go && (st_q == ST_IDLE)) begin
         instruction_code_line <= valid_d;
         ctl_group_q           <= cls_d;
         au_group_q            <= valid_d ?
                                  {au_double, au_multiply, 4'h0} | cls_d :
                                  `ICD_CL_NONE;
         sel_a_q               <= use_a_d;
         sel_m_q               <= use_m_d;
         mem_addr_fixed_q      <= disp_d;
         mem_addr_q            <= disp_d ? `ICD_DISP_LOC :
                                  {`ICD_ADDR_W{1'b0}};
         counter_load_ok_q     <= ctr_ok_d;
         cond_q                <= cond_d;
         m_dir_q               <= m_direct_d;
         stg_base_q            <= {1'b0, cls_d} * `ICD_STG_STEP;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stage sequencer, one step per phase-zero: A-input uses, idle while
   // the arithmetic unit works, then result uses
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q           <= ST_IDLE;
         ain_left_q     <= 3'd0;
         res_left_q     <= 2'd0;
         stage_q        <= 3'd0;
         busy_q         <= 1'b0;
         chain_a_in_q   <= 1'b0;
         chain_m_in_q   <= 1'b0;
         chain_result_q <= 1'b0;
         mem_ref_q      <= 1'b0;
         m_first_q      <= 1'b0;
      end else begin
         chain_a_in_q   <= 1'b0;
         chain_result_q <= 1'b0;
         mem_ref_q      <= 1'b0;
         chain_m_in_q   <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               stage_q <= 3'd0;
               if (decode_go && valid_d) begin
                  ain_left_q <= ain_n_d;
                  res_left_q <= res_n_d;
                  m_first_q  <= use_min_d;
                  busy_q     <= 1'b1;
                  st_q       <= ST_AIN;
               end
            end
            ST_AIN: begin
               // first step waits until the stage lines stand, so the gates see them
               if (timing_phase_zero && (pc_stage_line != {`ICD_STG_W{1'b0}})) begin
                  stage_q <= stage_q + 3'd1;
                  if (m_first_q) begin
                     chain_m_in_q <= 1'b1;
                     m_first_q    <= 1'b0;
                  end else if (ain_left_q != 3'd0) begin
                     chain_a_in_q <= 1'b1;
                     mem_ref_q    <= sel_m_q & ~ain_left_q[0]
                                     | (ain_left_q <= 3'd2) & sel_m_q;
                     ain_left_q   <= ain_left_q - 3'd1;
                  end else if (res_left_q != 2'd0) begin
                     st_q <= ST_WAIT;
                  end else begin
                     busy_q <= 1'b0;
                     st_q   <= ST_IDLE;
                  end
                  if (cond_q && transfer_taken) begin
                     busy_q <= 1'b0;
                     st_q   <= ST_IDLE;
                  end
               end
            end
            ST_WAIT: begin
               if (au_done) begin
                  st_q <= ST_RES;
               end
            end
            ST_RES: begin
               if (timing_phase_zero) begin
                  stage_q <= stage_q + 3'd1;
                  if (res_left_q != 2'd0) begin
                     chain_result_q <= 1'b1;
                     res_left_q     <= res_left_q - 2'd1;
                  end else begin
                     busy_q <= 1'b0;
                     st_q   <= ST_IDLE;
                  end
               end
            end
            default: begin
               st_q   <= ST_IDLE;
               busy_q <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // pc-stage line and the chain-start lines it raises
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_stage_line    <= {`ICD_STG_W{1'b0}};
         chain_start_line <= {`ICD_CHN_W{1'b0}};
      end else begin
         pc_stage_line    <= busy_q ? (stg_base_q + {4'h0, stage_q})
                                    : {`ICD_STG_W{1'b0}};
         chain_start_line <= {`ICD_CHN_W{1'b0}};
         if (busy_q) begin
            // several lines per stage; lines 03/04/42 feed the phase gates
            chain_start_line[`ICD_CH_A_INPUT]    <= (st_q == ST_AIN) &
                                                    (ain_left_q != 3'd0);
            chain_start_line[`ICD_CH_RESULT]     <= (st_q == ST_RES);
            chain_start_line[`ICD_CH_M_INPUT]    <= m_first_q;
            chain_start_line[`ICD_CH_SEL_LOAD_A] <= m_first_q & m_dir_q & ~cond_q;
            chain_start_line[`ICD_CH_SEL_LOAD_B] <= m_first_q & m_dir_q & cond_q;
            chain_start_line[`ICD_CH_LOW_DIGITS] <= (st_q == ST_AIN) &
                                                    (ctl_group_q ==
                                                     `ICD_CL_SHIFT_S |
                                                     ctl_group_q ==
                                                     `ICD_CL_SHIFT_D);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // phase-gated function signals; the selector bypasses the index adder
   icd_phase_gate #(.W(8)) u_low_digits (
      .clk      (clk),
      .rst_n    (rst_n),
      .line_in  (chain_start_line[`ICD_CH_LOW_DIGITS]),
      .phase_in (timing_phase_five),
      .data_in  (m_low_digits),
      .fn_q     (low_digit_transfer_fn),
      .data_q   (shift_control_reg)
   );

   icd_phase_gate #(.W(`ICD_SEL_W)) u_sel_load (
      .clk      (clk),
      .rst_n    (rst_n),
      .line_in  (chain_start_line[`ICD_CH_SEL_LOAD_A] |
                 chain_start_line[`ICD_CH_SEL_LOAD_B]),
      .phase_in (timing_phase_zero),
      .data_in  (a_field),
      .fn_q     (direct_selector_load_fn),
      .data_q   (selector_reg)
   );

endmodule // icd_decoder

// file: hw/icd_defines.vh
// icd_defines.vh: constants for the instruction control class decoder.
// assumes two-digit decimal order codes held as two bcd digits.
`ifndef ICD_DEFINES_VH
`define ICD_DEFINES_VH

// repertory and encoder sizes
`define ICD_NUM_INSTR      76
`define ICD_NUM_GROUPS     49
`define ICD_NUM_PC_STAGES  90
`define ICD_NUM_CHAINS     86

// widths
`define ICD_CODE_W         8
`define ICD_GRP_W          6
`define ICD_STG_W          7
`define ICD_CHN_W          88
`define ICD_SEL_W          8
`define ICD_ADDR_W         15

// control classes, also the control group number
`define ICD_CL_NONE        6'h00
`define ICD_CL_ARITH       6'h01
`define ICD_CL_EXT_L       6'h02
`define ICD_CL_EXT_X       6'h03
`define ICD_CL_SHIFT_S     6'h04
`define ICD_CL_SHIFT_D     6'h05
`define ICD_CL_FETCH       6'h06
`define ICD_CL_STORE       6'h07
`define ICD_CL_CMP_AM      6'h08
`define ICD_CL_CMP_A       6'h09
`define ICD_CL_INDEX       6'h0A
`define ICD_CL_INDEX_NC    6'h0B
`define ICD_CL_DISP_R      6'h0C
`define ICD_CL_DISP_W      6'h0D

// pc stage base per control group, stages step by 7
`define ICD_STG_STEP       7'h07

// chain-start line numbers
`define ICD_CH_A_INPUT     7'h01
`define ICD_CH_RESULT      7'h02
`define ICD_CH_SEL_LOAD_A  7'h03
`define ICD_CH_SEL_LOAD_B  7'h04
`define ICD_CH_M_INPUT     7'h05
`define ICD_CH_LOW_DIGITS  7'h2A

// fixed display memory location 02650 (octal)
`define ICD_DISP_LOC       15'h05A8

// reset values
`define ICD_SEL_RST        8'h00
`define ICD_SHC_RST        8'h00

`endif

// file: hw/icd_phase_gate.v
// icd_phase_gate.v: gates one chain-start line with one timing phase and
// loads a data register on the resulting function signal.
// assumes line, phase and data all come from logic on clk.
`timescale 1ns/1ps

module icd_phase_gate #(
   parameter W = 8
) (
   clk,
   rst_n,
   line_in,
   phase_in,
   data_in,
   fn_q,
   data_q
);
   input  wire         clk;
   input  wire         rst_n;
   input  wire         line_in;
   input  wire         phase_in;
   input  wire [W-1:0] data_in;
   output reg          fn_q;
   output reg  [W-1:0] data_q;

   ////////////////////////////////////////////////////////////////////////
   // one-cycle function pulse, data captured in the same edge
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fn_q   <= 1'b0;
         data_q <= {W{1'b0}};
      end else begin
         fn_q <= line_in & phase_in;
         if (line_in & phase_in) begin
            data_q <= data_in;
         end
      end
   end

endmodule // icd_phase_gate
